// *** sim/sfr_core_tb.sv ***
// self-checking bench of the serial front end core against a queue-free model
// assumes the host model in sfr_host.sv; the flag model masks channels like the core
module sfr_core_tb;
    import sfr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  clk;
    logic                  rst_b;
    logic                  por_n;
    logic [FAULT_BITS-1:0] fault_in;
    logic                  sclk;
    logic                  select_n;
    logic                  serial_in;
    logic                  serial_out;
    logic                  serial_out_oe;
    logic [CHANNELS-1:0]   gate_drive_out;
    sfr_cfg_type           cfg;
    logic                  fault_flag_n;
    logic                  fault_flag_n_oe;
    logic                  status_flag_n;
    logic                  status_flag_n_oe;
    logic [5:0]            m_gate;
    logic [5:0]            m_mode;
    logic [5:0]            m_refr;
    logic [5:0]            m_mask;
    logic [11:0]           m_latch;
    logic [31:0]           r;
    integer                seed = 32'hd24693fe;
    int                    fail_count = 0;
    int                    cmp_count = 0;

    always #4 clk = ~clk;

    sfr_host host (.serial_out(serial_out), .sclk(sclk), .select_n(select_n),
                   .serial_in(serial_in));

    sfr_core DUT (.clk(clk), .rst_b(rst_b), .por_n(por_n), .sclk(sclk),
                  .select_n(select_n), .serial_in(serial_in), .fault_in(fault_in),
                  .serial_out(serial_out), .serial_out_oe(serial_out_oe),
                  .gate_drive_out(gate_drive_out), .cfg(cfg), .fault_flag_n(fault_flag_n),
                  .fault_flag_n_oe(fault_flag_n_oe), .status_flag_n(status_flag_n),
                  .status_flag_n_oe(status_flag_n_oe));

    // ------------------------------------------------------------
    // comparison and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rx(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_ports();
        logic live;
        live = 1'b0;
        for (int i = 0; i < CHANNELS; i++)
            live = live | ((fault_in[2*i +: 2] != 2'b00) && !m_mask[i]);
        chk(32'(gate_drive_out), 32'(m_gate));
        chk(32'(cfg), 32'({m_mode, m_refr, m_mask}));
        chk(32'(status_flag_n_oe), 32'(|m_gate));
        chk(32'(fault_flag_n_oe), 32'(live));
        chk(32'(serial_out_oe), 32'h0);
        chk(32'({fault_flag_n, status_flag_n}), 32'h0);
    endtask

    // ------------------------------------------------------------
    // one frame through the host, model updated from the rules
    // ------------------------------------------------------------
    task automatic xfer(input int n, input logic [31:0] tx);
        logic [31:0] rx;
        logic [47:0] s;
        tx = (n == 32) ? tx : tx & ((32'h1 << n) - 32'h1);
        // out stream is the latched word, then what came in 16 bits earlier
        s = ({32'h0, FILL_ZERO, m_latch} << n) | {16'h0, tx};
        host.frame(n, tx, rx);
        chk_rx(rx, s[47:16]);
        if (n != 0 && n % 16 == 0) begin
            case (tx[15:12])
                ADDR_GATE: m_gate = tx[5:0];
                ADDR_MODE: m_mode = tx[5:0];
                ADDR_REFR: m_refr = tx[5:0];
                ADDR_MASK: m_mask = tx[5:0];
                default: ;
            endcase
            m_latch = fault_in;
        end
        chk_ports();
    endtask

    task automatic set_fault(input logic [11:0] v);
        @(posedge clk) #1 fault_in = v;
        m_latch = m_latch | v;
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #500000;
        fail_count++;
        results();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        por_n = 1'b1;
        fault_in = 12'h000;
        {m_gate, m_mode, m_refr, m_mask, m_latch} = '0;
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk_ports();
        // addresses 0 to 7, each twice, nulls included; mask kept zero
        for (int a = 0; a < 16; a++) begin
            r = $random(seed);
            r[15:12] = 4'(a % 8);
            if (a % 8 == 3)
                r[5:0] = 6'h00;
            xfer(16, r);
        end
        r = $random(seed);
        set_fault(r[11:0] | 12'h001);
        xfer(16, {16'h0, ADDR_GATE, 6'h0, r[21:16]});
        set_fault(12'h000);
        r = $random(seed);
        xfer(15, r);
        xfer(17, r);
        xfer(0, r);
        xfer(16, {16'h0, ADDR_MASK, 12'h0});
        xfer(16, {16'h0, ADDR_MASK, 12'h0});
        // channel 0 masked: its fault is latched but raises no flag
        xfer(16, {16'h0, ADDR_MASK, 12'h001});
        set_fault(12'h002);
        xfer(16, {16'h0, 4'h4, 12'h000});
        xfer(16, {16'h0, ADDR_MASK, 12'h000});
        set_fault(12'h000);
        r = $random(seed);
        // chained frame: only the last 16 bits act
        xfer(32, {ADDR_GATE, 6'h0, r[5:0], ADDR_GATE, 6'h0, r[21:16] | 6'h01});
        @(posedge clk) #1 por_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        {m_gate, m_mode, m_refr, m_mask, m_latch} = '0;
        chk_ports();
        @(posedge clk) #1 por_n = 1'b1;
        repeat (6) @(posedge clk);
        xfer(16, {16'h0, ADDR_GATE, 6'h0, r[29:24]});
        results();
    end
endmodule

// *** sim/sfr_host.sv ***
// host serial master model driving the link pins of the front end
// assumes the testbench calls frame() and that nothing else drives the link pins
module sfr_host (
    input  wire logic serial_out,
    output logic      sclk,
    output logic      select_n,
    output logic      serial_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // idle state
    // ------------------------------------------------------------
    initial begin
        sclk      = 1'b0;
        select_n  = 1'b1;
        serial_in = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame of n clocks, 30 ns shift clock, clock still between frames
    // ------------------------------------------------------------
    task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx       = 32'h0;
        select_n = 1'b0;
        #60;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = tx[i];
            #15;
            rx   = {rx[30:0], serial_out};
            sclk = 1'b1;
            #15;
            sclk = 1'b0;
        end
        #75;
        select_n  = 1'b1;
        // input pin has a pull-down once the host lets go
        serial_in = 1'b0;
        #1000;
    endtask
endmodule

// *** src/sfr_core.sv ***
// serial front end of a six channel gate pre-driver, core clock side
// assumes select_n, por_n and the link words come from other domains
//
// Operation
// - device is a 16-bit serial slave; host provides the shift clock
// - frame valid only when clock count per select is a non-zero multiple of 16
// - a frame error changes neither the fault flag nor the status flag
// - fault bits out and command bits in, both msb first, while selected
// - serial output changes on falling shift clock edges
// - serial input is set up before and sampled on rising edges
// - select fall restarts checking, loads fault word, clears and disables flag
// - faults arising during a frame are not latched until select rises
// - valid frame end decodes last 16 bits and re-enables the fault flag
// - valid frame end replaces the fault latch with present faults
// - frame error discards the command and keeps the old fault word
// - after a frame error only a real channel fault sets the flag
// - devices may share a host by selects or in a 16-bit chain
// - power-on reset holds gates low, defaults registers, disables flags
// - power-on release enables gates and flags and accepts commands
// - power-on reset again disables flags and forces gates low
// - sent word holds 12 fault bits low, upper four bits zero
// - command splits into top 4-bit address and low 6-bit data
module sfr_core
    import sfr_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    por_n,
    input  wire logic                    sclk,
    input  wire logic                    select_n,
    input  wire logic                    serial_in,
    input  wire logic [FAULT_BITS-1:0]   fault_in,
    output logic                         serial_out,
    output logic                         serial_out_oe,
    output logic [CHANNELS-1:0]          gate_drive_out,
    output sfr_cfg_type                  cfg,
    output logic                         fault_flag_n,
    output logic                         fault_flag_n_oe,
    output logic                         status_flag_n,
    output logic                         status_flag_n_oe
);
    import sfr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  sel_m;
        logic                  sel_s;
        logic                  sel_p;
        logic                  sck_m;
        logic                  sck_s;
        logic                  por_m;
        logic                  por_s;
        logic                  sck_p;
        logic                  clocked;
        sfr_phase_type         phase;
        logic                  flag_en;
        logic                  fault_flag;
        logic                  status_flag;
        logic [5:0]            gate_sel;
        sfr_cfg_type           cfg;
        logic [FAULT_BITS-1:0] latch;
    } sfr_state_type;

    localparam sfr_state_type RST_STATE = '{
        sel_m:       1'b1,
        sel_s:       1'b1,
        sel_p:       1'b1,
        sck_m:       1'b0,
        sck_s:       1'b0,
        por_m:       1'b0,
        por_s:       1'b0,
        sck_p:       1'b0,
        clocked:     1'b0,
        phase:       ST_OFF,
        flag_en:     1'b0,
        fault_flag:  1'b0,
        status_flag: 1'b0,
        gate_sel:    GATE_RST,
        cfg:         '{mode: MODE_RST, refresh: REFR_RST, mask: MASK_RST},
        latch:       FAULT_RST
    };

    sfr_state_type        s;
    sfr_state_type        next_s;
    sfr_rx_type           rx;
    logic                 frame_start;
    logic                 frame_end;
    logic                 frame_ok;
    logic [3:0]           cmd_addr;
    logic [5:0]           cmd_data;
    logic [CHANNELS-1:0]  live_fault;
    logic                 any_live;

    // ------------------------------------------------------------
    // link side
    // ------------------------------------------------------------
    sfr_link u_link (
        .sclk          (sclk),
        .select_n      (select_n),
        .serial_in     (serial_in),
        .fault_word    (s.latch),
        .serial_out    (serial_out),
        .serial_out_oe (serial_out_oe),
        .rx            (rx)
    );

    // ------------------------------------------------------------
    // per-channel fault summary
    // ------------------------------------------------------------
    // two code bits per channel; any non-zero code is a fault
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            assign live_fault[gi] = (|fault_in[2*gi +: 2]) & ~s.cfg.mask[gi];
        end
    endgenerate

    assign any_live = |live_fault;

    // ------------------------------------------------------------
    // frame events and command fields
    // ------------------------------------------------------------
    // rx fields are read only at frame end: sclk has stopped by then and
    // the two-stage select path gives them time to settle
    assign frame_start = s.sel_p & ~s.sel_s;
    assign frame_end   = ~s.sel_p & s.sel_s;
    // a frame with no clocks leaves a stale count behind; clocked rules it out
    assign frame_ok    = s.clocked && (rx.cnt == 4'h0);
    assign cmd_addr    = rx.word[ADDR_MSB:ADDR_LSB];
    assign cmd_data    = rx.word[DATA_MSB:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s       = s;
        next_s.sel_m = select_n;
        next_s.sel_s = s.sel_m;
        next_s.sel_p = s.sel_s;
        // shift clock sampled only to see that a frame had clocks at all
        next_s.sck_m = sclk;
        next_s.sck_s = s.sck_m;
        next_s.sck_p = s.sck_s;
        next_s.por_m = por_n;
        next_s.por_s = s.por_m;

        case (s.phase)
            ST_OFF: begin
                if (s.por_s) begin
                    next_s.phase   = ST_IDLE;
                    next_s.flag_en = 1'b1;
                end
            end
            ST_IDLE: begin
                // faults keep being captured only while deselected
                next_s.latch = s.latch | fault_in;
                if (s.flag_en && any_live) begin
                    next_s.fault_flag = 1'b1;
                end
                next_s.status_flag = |s.gate_sel;
                if (frame_start) begin
                    next_s.phase      = ST_FRAME;
                    next_s.flag_en    = 1'b0;
                    next_s.fault_flag = 1'b0;
                    next_s.clocked    = 1'b0;
                end
            end
            ST_FRAME: begin
                if (s.sck_s && !s.sck_p) begin
                    next_s.clocked = 1'b1;
                end
                if (frame_end) begin
                    next_s.phase    = ST_IDLE;
                    next_s.flag_en  = 1'b1;
                    if (frame_ok) begin
                        next_s.latch = fault_in;
                        // msb set or null block: no register is touched
                        if (cmd_addr == ADDR_GATE) begin
                            next_s.gate_sel = cmd_data;
                        end else if (cmd_addr == ADDR_MODE) begin
                            next_s.cfg.mode = cmd_data;
                        end else if (cmd_addr == ADDR_REFR) begin
                            next_s.cfg.refresh = cmd_data;
                        end else if (cmd_addr == ADDR_MASK) begin
                            next_s.cfg.mask = cmd_data;
                        end
                    end
                    // on error latch and registers stay as they are
                end
            end
            default: begin
                next_s.phase = ST_OFF;
            end
        endcase

        if (!s.por_s) begin
            next_s.phase       = ST_OFF;
            next_s.flag_en     = 1'b0;
            next_s.fault_flag  = 1'b0;
            next_s.status_flag = 1'b0;
            next_s.gate_sel    = GATE_RST;
            next_s.cfg         = RST_STATE.cfg;
            next_s.latch       = FAULT_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // flags are open drain: the pin only ever pulls low
    assign gate_drive_out   = s.gate_sel;
    assign cfg              = s.cfg;
    assign fault_flag_n     = 1'b0;
    assign fault_flag_n_oe  = s.fault_flag;
    assign status_flag_n    = 1'b0;
    assign status_flag_n_oe = s.status_flag;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_gate_por;
        @(posedge clk) disable iff (!rst_b)
        !s.por_s |=> (gate_drive_out == 6'h00) && !fault_flag_n_oe && !status_flag_n_oe;
    endproperty
    a_gate_por: assert property (p_gate_por)
        else $error("gates or flags active under power-on reset");

    property p_por_again;
        @(posedge clk) disable iff (!rst_b)
        $fell(s.por_s) |=> (s.phase == ST_OFF) ##1 (s.phase == ST_OFF || s.por_s);
    endproperty
    a_por_again: assert property (p_por_again)
        else $error("device not held off when power-on reset returns");

    property p_por_release;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_OFF) && s.por_s |=> (s.phase == ST_IDLE) && s.flag_en;
    endproperty
    a_por_release: assert property (p_por_release)
        else $error("device not enabled after power-on release");

    property p_flag_off_in_frame;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) |-> !fault_flag_n_oe && !s.flag_en;
    endproperty
    a_flag_off_in_frame: assert property (p_flag_off_in_frame)
        else $error("fault flag active while selected");

    property p_valid_gate;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) && frame_end && frame_ok && (cmd_addr == ADDR_GATE) && s.por_s
        |=> (gate_drive_out == $past(cmd_data)) && s.flag_en;
    endproperty
    a_valid_gate: assert property (p_valid_gate)
        else $error("valid gate command not applied");

    property p_valid_latch;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) && frame_end && frame_ok && s.por_s
        |=> (s.latch == $past(fault_in));
    endproperty
    a_valid_latch: assert property (p_valid_latch)
        else $error("fault latch not refreshed after valid frame");

    property p_error_keep;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) && frame_end && !frame_ok && s.por_s
        |=> $stable(s.latch) && $stable(gate_drive_out) && $stable(cfg);
    endproperty
    a_error_keep: assert property (p_error_keep)
        else $error("frame error altered latch or registers");

    property p_error_flags;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) && frame_end && !frame_ok && s.por_s
        |=> $stable(status_flag_n_oe) && $stable(fault_flag_n_oe);
    endproperty
    a_error_flags: assert property (p_error_flags)
        else $error("frame error changed a flag");

    property p_flag_cause;
        @(posedge clk) disable iff (!rst_b)
        $rose(fault_flag_n_oe) |-> $past(any_live);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("fault flag set without a channel fault");

    property p_latch_frozen;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) && !frame_end && s.por_s |=> $stable(s.latch);
    endproperty
    a_latch_frozen: assert property (p_latch_frozen)
        else $error("fault latch changed during a frame");

    property p_end_sync;
        @(posedge clk) disable iff (!rst_b)
        $rose(s.sel_m) |-> ##1 frame_end;
    endproperty
    a_end_sync: assert property (p_end_sync)
        else $error("frame end not seen one cycle after select rise");

    property p_so_release;
        @(posedge clk) disable iff (!rst_b)
        select_n |-> !serial_out_oe;
    endproperty
    a_so_release: assert property (p_so_release)
        else $error("serial output driven while deselected");

    property p_frame_restart;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_IDLE) && frame_start && s.por_s
        |=> (s.phase == ST_FRAME) && !s.clocked;
    endproperty
    a_frame_restart: assert property (p_frame_restart)
        else $error("frame start did not restart the frame check");

    property p_status_frozen;
        @(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) && s.por_s |=> $stable(status_flag_n_oe);
    endproperty
    a_status_frozen: assert property (p_status_frozen)
        else $error("status flag changed during a frame");

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    c_valid_frame: cover property (@(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) && frame_end && frame_ok);
    c_error_frame: cover property (@(posedge clk) disable iff (!rst_b)
        (s.phase == ST_FRAME) && frame_end && !frame_ok);
    c_flag_set: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(fault_flag_n_oe));
    c_por_cycle: cover property (@(posedge clk) disable iff (!rst_b)
        $fell(s.por_s));
    c_masked_fault: cover property (@(posedge clk) disable iff (!rst_b)
        (s.phase == ST_IDLE) && (|fault_in) && !any_live);

endmodule

// *** src/sfr_link.sv ***
// shift-clock side of the serial port: receive shifter, bit count, transmit bit
// assumes sclk stops while select_n is high; fault_word is static during a frame
module sfr_link
    import sfr_pkg::*;
(
    input  wire logic                    sclk,
    input  wire logic                    select_n,
    input  wire logic                    serial_in,
    input  wire logic [FAULT_BITS-1:0]   fault_word,
    output logic                         serial_out,
    output logic                         serial_out_oe,
    output sfr_rx_type                   rx
);
    import sfr_pkg::*;

    typedef struct packed {
        logic [4:0] nf;
        logic       tx;
    } sfr_fall_type;

    sfr_rx_type   pos;
    sfr_rx_type   next_pos;
    sfr_fall_type neg;
    sfr_fall_type next_neg;
    logic         armed;
    logic [15:0]  tx_word;
    logic [4:0]   idx;

    assign tx_word = {FILL_ZERO, fault_word};

    // ------------------------------------------------------------
    // rising edge: sample command bits
    // ------------------------------------------------------------
    // armed marks the first edge of a frame; the count itself is kept
    // after the frame so the core can judge it once select_n is high
    always_ff @(posedge sclk or posedge select_n) begin
        if (select_n) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end

    always_comb begin
        next_pos      = pos;
        next_pos.word = {pos.word[14:0], serial_in};
        if (!armed) begin
            next_pos.cnt = 4'h1;
            next_pos.tog = ~pos.tog;
        end else begin
            next_pos.cnt = 4'(pos.cnt + 4'h1);
        end
    end

    always_ff @(posedge sclk) begin
        pos <= next_pos;
    end

    // ------------------------------------------------------------
    // falling edge: next transmit bit, then pass-through for a chain
    // ------------------------------------------------------------
    always_comb begin
        next_neg    = neg;
        next_neg.nf = (neg.nf == 5'd16) ? neg.nf : 5'(neg.nf + 5'd1);
        idx         = 5'(5'd15 - next_neg.nf);
        if (next_neg.nf < 5'd16) begin
            next_neg.tx = tx_word[idx[3:0]];
        end else begin
            next_neg.tx = pos.word[15];
        end
    end

    always_ff @(negedge sclk or posedge select_n) begin
        if (select_n) begin
            neg <= '0;
        end else begin
            neg <= next_neg;
        end
    end

    assign serial_out    = (neg.nf == 5'd0) ? tx_word[15] : neg.tx;
    assign serial_out_oe = ~select_n;
    assign rx            = pos;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_tx_order;
        @(negedge sclk) disable iff (select_n)
        (neg.nf < 5'd15) |=> (serial_out == tx_word[4'(5'd15 - neg.nf)]);
    endproperty
    a_tx_order: assert property (p_tx_order)
        else $error("transmit bit out of order");

endmodule

// *** src/sfr_pkg.sv ***
// shared constants and carriers of the serial front end
// assumes one core clock and a host-driven shift clock
package sfr_pkg;

    // ------------------------------------------------------------
    // frame and word layout
    // ------------------------------------------------------------
    localparam int          WORD_BITS  = 16;
    localparam int          FAULT_BITS = 12;
    localparam int          CHANNELS   = 6;
    localparam int          ADDR_MSB   = 15;
    localparam int          ADDR_LSB   = 12;
    localparam int          DATA_MSB   = 5;
    localparam logic [3:0]  FILL_ZERO  = 4'h0;

    // ------------------------------------------------------------
    // command addresses and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_GATE  = 4'h0;
    localparam logic [3:0]  ADDR_MODE  = 4'h1;
    localparam logic [3:0]  ADDR_REFR  = 4'h2;
    localparam logic [3:0]  ADDR_MASK  = 4'h3;
    localparam logic [5:0]  GATE_RST   = 6'h00;
    localparam logic [5:0]  MODE_RST   = 6'h00;
    localparam logic [5:0]  REFR_RST   = 6'h00;
    localparam logic [5:0]  MASK_RST   = 6'h00;
    localparam logic [11:0] FAULT_RST  = 12'h000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int XFER_GAP_NS   = 1000;
    localparam int XFER_GAP_CYC  = (XFER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] mode;
        logic [5:0] refresh;
        logic [5:0] mask;
    } sfr_cfg_type;

    typedef struct packed {
        logic [15:0] word;
        logic [3:0]  cnt;
        logic        tog;
    } sfr_rx_type;

    typedef enum {ST_OFF, ST_IDLE, ST_FRAME} sfr_phase_type;

endpackage
